// ---- include/mcs_map.vh ----
`ifndef MCS_MAP_VH
`define MCS_MAP_VH

// register byte offsets
`define MCS_REG_CTRL 8'h00
`define MCS_REG_WDT 8'h04
`define MCS_REG_STAT 8'h08
`define MCS_REG_SENDEN 8'h0c
`define MCS_REG_RELAY 8'h10
`define MCS_REG_SW 8'h14
`define MCS_REG_SWN 8'h18
`define MCS_REG_NODE 8'h1c
`define MCS_REG_CMD 8'h40
`define MCS_REG_FB 8'h60
`define MCS_AXIS_SPAN 8'h18

// control register fields
`define MCS_CTRL_WD_EN 0
`define MCS_CTRL_PWR_REQ 1
`define MCS_CTRL_HOST_RUN 2

// status register fields
`define MCS_ST_WD_EXP 0
`define MCS_ST_FAULT 1
`define MCS_ST_PWR_ON 2
`define MCS_ST_CAN_FULL 3
`define MCS_ST_BUS_ERR 4
`define MCS_ST_BOOTED 5
`define MCS_ST_DISC 6

// reset values
`define MCS_CTRL_RST 32'h0000_0000
`define MCS_WDT_RST 32'h0000_0000

// can frame format
`define MCS_CAN_CMD_ID 11'h010
`define MCS_CAN_FB_ID 11'h020
`define MCS_CAN_DLC 4'h4
`define MCS_AXES 6

// timing, times in ns
`define MCS_CLK_NS 10
`define MCS_CAN_BIT_NS 1000
`define MCS_CAN_BIT_CYC (`MCS_CAN_BIT_NS / `MCS_CLK_NS)
`define MCS_BLINK_NS 250000000
`define MCS_BLINK_CYC (`MCS_BLINK_NS / `MCS_CLK_NS)
`define MCS_NODE_TICK_NS 1000000
`define MCS_NODE_TICK_CYC (`MCS_NODE_TICK_NS / `MCS_CLK_NS)
`define MCS_DISC_TICKS 100
`define MCS_NODE_TIMEOUT_TICKS 10

`endif

// ---- logic/mcs_ram.v ----
`timescale 1ns/1ps
module mcs_ram #(
	parameter AW = 3,
	parameter DW = 32
) (
	input wire clk,
	input wire we,
	input wire [AW-1:0] waddr,
	input wire [DW-1:0] wdata,
	input wire re,
	input wire [AW-1:0] raddr,
	output reg [DW-1:0] rdata
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	// no reset on the array: contents are undefined until written
	always @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		if (re) begin
			rdata <= mem[raddr];
		end
	end
endmodule

// ---- logic/mcs_sync.v ----
`timescale 1ns/1ps
module mcs_sync #(
	parameter W = 1
) (
	input wire clk,
	input wire rstn,
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
	reg [W-1:0] meta_q;

	always @(posedge clk) begin
		if (!rstn) begin
			meta_q <= {W{1'b0}};
			q <= {W{1'b0}};
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

// ---- logic/mcs_top.v ----
// Function
// - can frames: 11-bit identifier, four data bytes
// - can link runs at one megabit per second
// - axis n command sent with identifier 0x10+n
// - send commands only while axis send-enable set
// - each host service read reloads the watchdog
// - readable flag shows watchdog has expired
// - expiry forces all power enables low in hardware
// - watchdog counts only while its enable set
// - can led: blink traffic, on full, else off
// - rs485 led: blink init, on healthy, off dropped
// - host led blinks while host software runs
// - boot led lights after successful boot only
// - error led: off, blink bus error, on watchdog
// - drop rs485 nodes that stop answering regularly
// - unique 4-bit node addresses found at startup
// - limit and home switches sampled, plain and negated
// - per-relay inversion setting negates relay output
// - power enable needs request, no expiry, no fault
`timescale 1ns/1ps
`include "mcs_map.vh"
module mcs_top #(
	parameter BLINK_CYCLES = `MCS_BLINK_CYC,
	parameter NODE_TICK_CYCLES = `MCS_NODE_TICK_CYC,
	parameter [15:0] DISC_TICKS = `MCS_DISC_TICKS,
	parameter [7:0] NODE_TIMEOUT_TICKS = `MCS_NODE_TIMEOUT_TICKS,
	parameter PWR_OUTS = 7
) (
	input wire MCLK,
	input wire RSTN,
	input wire [7:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	output wire S_AXI_AWREADY,
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output wire S_AXI_WREADY,
	output reg [1:0] S_AXI_BRESP,
	output reg S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire [7:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	output wire S_AXI_ARREADY,
	output reg [31:0] S_AXI_RDATA,
	output reg [1:0] S_AXI_RRESP,
	output reg S_AXI_RVALID,
	input wire S_AXI_RREADY,
	input wire [5:0] LOWER_LIMIT_SWITCH_LEVEL,
	input wire [5:0] UPPER_LIMIT_SWITCH_LEVEL,
	input wire [5:0] HOME_SWITCH_LEVEL,
	input wire AMP_POWER_FAULT,
	output reg [PWR_OUTS-1:0] AMP_POWER_ENABLE,
	output reg CAN_TX_VALID,
	input wire CAN_TX_READY,
	output reg [10:0] CAN_TX_ID,
	output wire [3:0] CAN_TX_DLC,
	output wire [31:0] CAN_TX_DATA,
	input wire CAN_RX_VALID,
	input wire CAN_RX_EXT,
	input wire [10:0] CAN_RX_ID,
	input wire [3:0] CAN_RX_DLC,
	input wire [31:0] CAN_RX_DATA,
	input wire CAN_BUF_FULL,
	output reg CAN_BIT_TICK,
	input wire NODE_ANS_VALID,
	input wire [3:0] NODE_ANS_ADDR,
	output reg [7:0] RELAY_OUT,
	output reg LED_CAN,
	output reg LED_RS485,
	output reg HOST_ACTIVITY_INDICATOR,
	output reg LED_BOOT,
	output reg LED_ERROR
);
	localparam ST_IDLE = 3'b001;
	localparam ST_FETCH = 3'b010;
	localparam ST_SEND = 3'b100;

	function map_ok;
		input [7:0] a;
		begin
			if (a[1:0] != 2'b00) begin
				map_ok = 1'b0;
			end else if (a <= `MCS_REG_NODE) begin
				map_ok = 1'b1;
			end else if (a >= `MCS_REG_CMD && a < `MCS_REG_CMD + `MCS_AXIS_SPAN) begin
				map_ok = 1'b1;
			end else if (a >= `MCS_REG_FB && a < `MCS_REG_FB + `MCS_AXIS_SPAN) begin
				map_ok = 1'b1;
			end else begin
				map_ok = 1'b0;
			end
		end
	endfunction

	function [2:0] axis_idx;
		input [7:0] a;
		begin
			axis_idx = a[4:2];
		end
	endfunction

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					merge[i*8 +: 8] = nw[i*8 +: 8];
				end
			end
		end
	endfunction

	function [2:0] first_axis;
		input [5:0] v;
		integer i;
		begin
			first_axis = 3'd0;
			for (i = 5; i >= 0; i = i - 1) begin
				if (v[i]) begin
					first_axis = i[2:0];
				end
			end
		end
	endfunction

	wire [18:0] pins_s;
	wire [17:0] sw_s = pins_s[17:0];
	wire fault_s = pins_s[18];
	// pins are asynchronous to MCLK
	mcs_sync #(.W(19)) u_sync (
		.clk(MCLK),
		.rstn(RSTN),
		.d({AMP_POWER_FAULT, HOME_SWITCH_LEVEL, UPPER_LIMIT_SWITCH_LEVEL, LOWER_LIMIT_SWITCH_LEVEL}),
		.q(pins_s)
	);

	reg [31:0] ctrl_q, wdt_q, wd_cnt_q, blink_cnt_q, tick_cnt_q;
	reg [5:0] senden_q, pending_q, pending_d;
	reg [15:0] relay_q, disc_cnt_q;
	reg [6:0] bit_cnt_q;
	reg wd_exp_q, wd_en_d1_q, bus_err_q, blink_q, blink_tick_q, node_tick_q, disc_done_q;
	reg can_act_q, can_recent_q;
	reg aw_full_q, w_full_q, rd_busy_q;
	reg [7:0] aw_addr_q, rd_addr_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg [2:0] state_q, tx_axis_q;
	wire [15:0] node_init, node_act;
	wire [31:0] fb_q;

	// AXI4-Lite write channel: address and data taken in either order
	assign S_AXI_AWREADY = !aw_full_q && !S_AXI_BVALID;
	assign S_AXI_WREADY = !w_full_q && !S_AXI_BVALID;
	wire aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
	wire w_hs = S_AXI_WVALID && S_AXI_WREADY;
	wire do_wr = aw_full_q && w_full_q && !S_AXI_BVALID;
	wire wr_ok = map_ok(aw_addr_q);
	wire cmd_wr = do_wr && aw_addr_q >= `MCS_REG_CMD && aw_addr_q < `MCS_REG_CMD + `MCS_AXIS_SPAN
		&& w_strb_q == 4'hf;
	wire [2:0] wr_axis = axis_idx(aw_addr_q - `MCS_REG_CMD);
	wire stat_wr = do_wr && aw_addr_q == `MCS_REG_STAT && w_strb_q[0];
	wire [31:0] relay_m = merge({16'h0000, relay_q}, w_data_q, w_strb_q);

	assign S_AXI_ARREADY = !rd_busy_q && !S_AXI_RVALID;
	wire ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
	wire svc = ar_hs && S_AXI_ARADDR == `MCS_REG_STAT;
	wire tx_done = (state_q == ST_SEND) && CAN_TX_READY;
	wire rx_ok = CAN_RX_VALID && !CAN_RX_EXT && CAN_RX_DLC == `MCS_CAN_DLC
		&& CAN_RX_ID >= `MCS_CAN_FB_ID && CAN_RX_ID < `MCS_CAN_FB_ID + `MCS_AXES;
	wire [10:0] rx_off = CAN_RX_ID - `MCS_CAN_FB_ID;
	wire wd_en = ctrl_q[`MCS_CTRL_WD_EN];
	wire [5:0] tx_ready = pending_q & senden_q;

	always @(posedge MCLK) begin
		if (!RSTN) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= 2'b00;
			ctrl_q <= `MCS_CTRL_RST;
			wdt_q <= `MCS_WDT_RST;
			senden_q <= 6'h00;
			relay_q <= 16'h0000;
		end else begin
			if (aw_hs) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= S_AXI_AWADDR;
			end
			if (w_hs) begin
				w_full_q <= 1'b1;
				w_data_q <= S_AXI_WDATA;
				w_strb_q <= S_AXI_WSTRB;
			end
			if (do_wr) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= wr_ok ? 2'b00 : 2'b10;
				if (aw_addr_q == `MCS_REG_CTRL) begin
					ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q) & 32'h0000_0007;
				end else if (aw_addr_q == `MCS_REG_WDT) begin
					wdt_q <= merge(wdt_q, w_data_q, w_strb_q);
				end else if (aw_addr_q == `MCS_REG_SENDEN) begin
					senden_q <= w_strb_q[0] ? w_data_q[5:0] : senden_q;
				end else if (aw_addr_q == `MCS_REG_RELAY) begin
					relay_q <= relay_m[15:0];
				end
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// read: address taken, feedback memory read, data registered
	always @(posedge MCLK) begin
		if (!RSTN) begin
			rd_busy_q <= 1'b0;
			rd_addr_q <= 8'h00;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0000_0000;
			S_AXI_RRESP <= 2'b00;
		end else if (ar_hs) begin
			rd_busy_q <= 1'b1;
			rd_addr_q <= S_AXI_ARADDR;
		end else if (rd_busy_q) begin
			rd_busy_q <= 1'b0;
			S_AXI_RVALID <= 1'b1;
			S_AXI_RRESP <= map_ok(rd_addr_q) ? 2'b00 : 2'b10;
			if (rd_addr_q == `MCS_REG_CTRL) begin
				S_AXI_RDATA <= ctrl_q;
			end else if (rd_addr_q == `MCS_REG_WDT) begin
				S_AXI_RDATA <= wdt_q;
			end else if (rd_addr_q == `MCS_REG_STAT) begin
				S_AXI_RDATA <= {25'h0, !disc_done_q, disc_done_q, bus_err_q, CAN_BUF_FULL,
					AMP_POWER_ENABLE[0], fault_s, wd_exp_q};
			end else if (rd_addr_q == `MCS_REG_SENDEN) begin
				S_AXI_RDATA <= {26'h0, senden_q};
			end else if (rd_addr_q == `MCS_REG_RELAY) begin
				S_AXI_RDATA <= {16'h0, relay_q};
			end else if (rd_addr_q == `MCS_REG_SW) begin
				S_AXI_RDATA <= {14'h0, sw_s};
			end else if (rd_addr_q == `MCS_REG_SWN) begin
				S_AXI_RDATA <= {14'h0, ~sw_s};
			end else if (rd_addr_q == `MCS_REG_NODE) begin
				S_AXI_RDATA <= {node_init, node_act};
			end else if (rd_addr_q >= `MCS_REG_FB && map_ok(rd_addr_q)) begin
				S_AXI_RDATA <= fb_q;
			end else begin
				S_AXI_RDATA <= 32'h0000_0000;
			end
		end else if (S_AXI_RVALID && S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

	mcs_ram #(.AW(3), .DW(32)) u_cmd_ram (
		.clk(MCLK),
		.we(cmd_wr),
		.waddr(wr_axis),
		.wdata(w_data_q),
		.re(state_q == ST_FETCH),
		.raddr(tx_axis_q),
		.rdata(CAN_TX_DATA)
	);

	// feedback_axis_position store, one word per axis
	mcs_ram #(.AW(3), .DW(32)) u_fb_ram (
		.clk(MCLK),
		.we(rx_ok),
		.waddr(rx_off[2:0]),
		.wdata(CAN_RX_DATA),
		.re(ar_hs),
		.raddr(axis_idx(S_AXI_ARADDR - `MCS_REG_FB)),
		.rdata(fb_q)
	);

	assign CAN_TX_DLC = `MCS_CAN_DLC;

	// frame data latched in fetch; a later write to that axis is sent again
	always @* begin
		pending_d = pending_q;
		if (state_q == ST_FETCH) begin
			pending_d[tx_axis_q] = 1'b0;
		end
		if (cmd_wr) begin
			pending_d[wr_axis] = 1'b1;
		end
	end

	always @(posedge MCLK) begin
		if (!RSTN) begin
			state_q <= ST_IDLE;
			tx_axis_q <= 3'd0;
			pending_q <= 6'h00;
			CAN_TX_VALID <= 1'b0;
			CAN_TX_ID <= 11'h000;
		end else begin
			pending_q <= pending_d;
			case (state_q)
				ST_IDLE: begin
					if (|tx_ready) begin
						tx_axis_q <= first_axis(tx_ready);
						state_q <= ST_FETCH;
					end
				end
				ST_FETCH: begin
					CAN_TX_VALID <= 1'b1;
					CAN_TX_ID <= `MCS_CAN_CMD_ID + {8'h00, tx_axis_q};
					state_q <= ST_SEND;
				end
				ST_SEND: begin
					if (CAN_TX_READY) begin
						CAN_TX_VALID <= 1'b0;
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// dividers: can bit enable, blink rate, node supervision tick
	always @(posedge MCLK) begin
		if (!RSTN) begin
			bit_cnt_q <= 7'd0;
			CAN_BIT_TICK <= 1'b0;
			blink_cnt_q <= 32'd0;
			blink_tick_q <= 1'b0;
			blink_q <= 1'b0;
			tick_cnt_q <= 32'd0;
			node_tick_q <= 1'b0;
			disc_cnt_q <= 16'd0;
			disc_done_q <= 1'b0;
		end else begin
			CAN_BIT_TICK <= bit_cnt_q == `MCS_CAN_BIT_CYC - 1;
			bit_cnt_q <= (bit_cnt_q == `MCS_CAN_BIT_CYC - 1) ? 7'd0 : bit_cnt_q + 7'd1;
			blink_tick_q <= blink_cnt_q == BLINK_CYCLES - 1;
			blink_cnt_q <= (blink_cnt_q == BLINK_CYCLES - 1) ? 32'd0 : blink_cnt_q + 32'd1;
			if (blink_tick_q) begin
				blink_q <= !blink_q;
			end
			node_tick_q <= tick_cnt_q == NODE_TICK_CYCLES - 1;
			tick_cnt_q <= (tick_cnt_q == NODE_TICK_CYCLES - 1) ? 32'd0 : tick_cnt_q + 32'd1;
			if (node_tick_q && !disc_done_q) begin
				disc_cnt_q <= disc_cnt_q + 16'd1;
				disc_done_q <= disc_cnt_q == DISC_TICKS - 16'd1;
			end
		end
	end

	// node supervision, one tracker per 4-bit address
	genvar g;
	generate
		for (g = 0; g < 16; g = g + 1) begin : node
			reg [7:0] age_q;
			reg init_q, act_q;
			wire hit = NODE_ANS_VALID && NODE_ANS_ADDR == g;
			always @(posedge MCLK) begin
				if (!RSTN) begin
					age_q <= 8'd0;
					init_q <= 1'b0;
					act_q <= 1'b0;
				end else begin
					if (hit) begin
						age_q <= 8'd0;
					end else if (node_tick_q && age_q != NODE_TIMEOUT_TICKS) begin
						age_q <= age_q + 8'd1;
					end
					if (!disc_done_q && hit) begin
						init_q <= 1'b1;
						act_q <= 1'b1;
					end else if (!hit && node_tick_q && age_q == NODE_TIMEOUT_TICKS - 8'd1) begin
						act_q <= 1'b0;
					end
				end
			end
			assign node_init[g] = init_q;
			assign node_act[g] = act_q;
		end
	endgenerate

	// watchdog, power, status flags and indicators
	always @(posedge MCLK) begin
		if (!RSTN) begin
			wd_cnt_q <= 32'd0;
			wd_exp_q <= 1'b0;
			wd_en_d1_q <= 1'b0;
			bus_err_q <= 1'b0;
			can_act_q <= 1'b0;
			can_recent_q <= 1'b0;
			AMP_POWER_ENABLE <= {PWR_OUTS{1'b0}};
			RELAY_OUT <= 8'h00;
			LED_CAN <= 1'b0;
			LED_RS485 <= 1'b0;
			HOST_ACTIVITY_INDICATOR <= 1'b0;
			LED_BOOT <= 1'b0;
			LED_ERROR <= 1'b0;
		end else begin
			wd_en_d1_q <= wd_en;
			if (!wd_en || svc) begin
				wd_cnt_q <= 32'd0;
			end else if (wd_cnt_q < wdt_q) begin
				wd_cnt_q <= wd_cnt_q + 32'd1;
			end
			if (wd_en && !svc && wd_cnt_q >= wdt_q) begin
				wd_exp_q <= 1'b1;
			end else if (wd_en && !wd_en_d1_q) begin
				wd_exp_q <= 1'b0;
			end
			// error set beats the software clear
			if ((do_wr && !wr_ok) || (rd_busy_q && !map_ok(rd_addr_q))) begin
				bus_err_q <= 1'b1;
			end else if (stat_wr && w_data_q[`MCS_ST_BUS_ERR]) begin
				bus_err_q <= 1'b0;
			end
			AMP_POWER_ENABLE <= {PWR_OUTS{ctrl_q[`MCS_CTRL_PWR_REQ] && !wd_exp_q && !fault_s}};
			RELAY_OUT <= relay_q[7:0] ^ relay_q[15:8];
			if (tx_done || rx_ok) begin
				can_act_q <= 1'b1;
			end else if (blink_tick_q) begin
				can_act_q <= 1'b0;
			end
			if (blink_tick_q) begin
				can_recent_q <= can_act_q;
			end
			LED_CAN <= CAN_BUF_FULL || (can_recent_q && blink_q);
			if (!disc_done_q) begin
				LED_RS485 <= blink_q;
			end else begin
				LED_RS485 <= (|node_init) && ((node_init & ~node_act) == 16'h0000);
			end
			HOST_ACTIVITY_INDICATOR <= ctrl_q[`MCS_CTRL_HOST_RUN] && blink_q;
			LED_BOOT <= disc_done_q;
			LED_ERROR <= wd_exp_q || (bus_err_q && blink_q);
		end
	end
endmodule

// ---- test/mcs_partner.sv ----
`timescale 1ns/1ps
module mcs_partner (
	input logic MCLK,
	input logic CAN_TX_VALID,
	input logic slow,
	input logic [15:0] node_mask,
	output logic CAN_TX_READY,
	output logic CAN_RX_VALID,
	output logic CAN_RX_EXT,
	output logic [10:0] CAN_RX_ID,
	output logic [3:0] CAN_RX_DLC,
	output logic [31:0] CAN_RX_DATA,
	output logic NODE_ANS_VALID,
	output logic [3:0] NODE_ANS_ADDR
);
	int wait_n = 0;
	logic [2:0] nd = 3'h0;
	initial begin
		{CAN_TX_READY, CAN_RX_VALID, CAN_RX_EXT, NODE_ANS_VALID} = 4'h0;
		{CAN_RX_ID, CAN_RX_DLC, CAN_RX_DATA, NODE_ANS_ADDR} = 51'h0;
	end
	// amplifier takes a frame at once, or after five cycles when slow
	always @(posedge MCLK) begin
		CAN_TX_READY <= 1'b0;
		if (CAN_TX_VALID && !CAN_TX_READY) begin
			if (wait_n >= (slow ? 5 : 0)) begin
				CAN_TX_READY <= 1'b1;
				wait_n <= 0;
			end else begin
				wait_n <= wait_n + 1;
			end
		end
	end
	// listed nodes 0 to 7 answer once in eight cycles, inside the drop time; 8 to 15 never answer
	// a node left out of node_mask is silent, as one in its error state
	always @(posedge MCLK) begin
		nd <= nd + 3'h1;
		NODE_ANS_VALID <= node_mask[nd];
		NODE_ANS_ADDR <= {1'b0, nd};
	end
	// id and data lines are scrambled after the pulse so no stale frame lingers
	task send_fb(input logic [10:0] id, input logic ext, input logic [3:0] dlc, input logic [31:0] dat);
		@(posedge MCLK);
		CAN_RX_VALID <= 1'b1;
		CAN_RX_EXT <= ext;
		CAN_RX_ID <= id;
		CAN_RX_DLC <= dlc;
		CAN_RX_DATA <= dat;
		@(posedge MCLK);
		CAN_RX_VALID <= 1'b0;
		CAN_RX_ID <= ~id;
		CAN_RX_DATA <= ~dat;
	endtask
endmodule

// ---- test/mcs_top_chk.sv ----
`timescale 1ns/1ps
module mcs_top_chk (
	input wire MCLK,
	input wire RSTN,
	input wire S_AXI_AWREADY,
	input wire S_AXI_WREADY,
	input wire [1:0] S_AXI_BRESP,
	input wire S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire S_AXI_ARVALID,
	input wire S_AXI_ARREADY,
	input wire [31:0] S_AXI_RDATA,
	input wire S_AXI_RVALID,
	input wire S_AXI_RREADY,
	input wire AMP_POWER_FAULT,
	input wire [6:0] AMP_POWER_ENABLE,
	input wire CAN_TX_VALID,
	input wire CAN_TX_READY,
	input wire [10:0] CAN_TX_ID,
	input wire [3:0] CAN_TX_DLC,
	input wire [31:0] CAN_TX_DATA,
	input wire CAN_BIT_TICK
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RSTN);
	sequence s_tx_wait;
		CAN_TX_VALID && !CAN_TX_READY;
	endsequence
	sequence s_tx_done;
		CAN_TX_VALID && CAN_TX_READY;
	endsequence
	a_tick_period: assert property (CAN_BIT_TICK |=> !CAN_BIT_TICK ##99 CAN_BIT_TICK)
		else $error("bit tick period wrong");
	a_tx_format: assert property (CAN_TX_VALID |-> CAN_TX_DLC == 4'h4 && CAN_TX_ID inside {[11'h010:11'h015]})
		else $error("frame id or length wrong");
	a_tx_hold: assert property (s_tx_wait |=> CAN_TX_VALID && $stable(CAN_TX_ID) && $stable(CAN_TX_DATA))
		else $error("frame changed while waiting");
	a_tx_gap: assert property (s_tx_done |=> !CAN_TX_VALID)
		else $error("no idle cycle after frame");
	a_pwr_fault: assert property (AMP_POWER_FAULT [*4] |=> AMP_POWER_ENABLE == 7'h00)
		else $error("power enable high during fault");
	a_pwr_equal: assert property (AMP_POWER_ENABLE == 7'h00 || AMP_POWER_ENABLE == 7'h7f)
		else $error("power enables differ");
	a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped");
	a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data dropped");
	a_w_block: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("write taken during response");
	a_r_latency: assert property (S_AXI_ARVALID && S_AXI_ARREADY |-> ##[1:2] S_AXI_RVALID)
		else $error("read answer late");
endmodule
bind mcs_top mcs_top_chk mcs_top_chk_inst (.*);

// ---- test/mcs_top_test.sv ----
`timescale 1ns/1ps
`include "mcs_map.vh"
module mcs_top_test;
	typedef struct packed {
		logic [31:0] w;
		logic [17:0] sw;
		logic [7:0] relay;
	} row_t;
	logic MCLK = 0;
	logic RSTN = 0;
	logic [7:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
	logic [31:0] S_AXI_WDATA = 0;
	logic [3:0] S_AXI_WSTRB = 4'hf;
	logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0, S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
	logic [5:0] LOWER_LIMIT_SWITCH_LEVEL = 0, UPPER_LIMIT_SWITCH_LEVEL = 0, HOME_SWITCH_LEVEL = 0;
	logic AMP_POWER_FAULT = 0, CAN_BUF_FULL = 0, slow = 0;
	logic [15:0] node_mask = 16'h0028;
	wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
	wire [31:0] S_AXI_RDATA, CAN_TX_DATA, CAN_RX_DATA;
	wire [6:0] AMP_POWER_ENABLE;
	wire [10:0] CAN_TX_ID, CAN_RX_ID;
	wire [3:0] CAN_TX_DLC, CAN_RX_DLC, NODE_ANS_ADDR;
	wire [7:0] RELAY_OUT;
	wire CAN_TX_VALID, CAN_TX_READY, CAN_RX_VALID, CAN_RX_EXT, CAN_BIT_TICK, NODE_ANS_VALID;
	wire LED_CAN, LED_RS485, HOST_ACTIVITY_INDICATOR, LED_BOOT, LED_ERROR;
	int miscompares = 0, n_tests = 0;
	logic [31:0] d;
	logic [1:0] resp, seen, blk;
	logic [42:0] txq[$];
	row_t rows[4] = '{'{32'h00a5, 18'h00000, 8'ha5}, '{32'hff00, 18'h3ffff, 8'hff},
		'{32'h0f3c, 18'h2a5c3, 8'h33}, '{32'hffff, 18'h15a3c, 8'h00}};
	mcs_top #(.BLINK_CYCLES(8), .NODE_TICK_CYCLES(4), .DISC_TICKS(3), .NODE_TIMEOUT_TICKS(3)) mcs_top_inst (.*);
	mcs_partner mcs_partner_inst (.*);
	initial forever #5 MCLK = ~MCLK;
	always @(posedge MCLK) begin
		if (CAN_TX_VALID && CAN_TX_READY) txq.push_back({CAN_TX_ID, CAN_TX_DATA});
		if (HOST_ACTIVITY_INDICATOR === 1'b1) seen[1] <= 1'b1;
		if (HOST_ACTIVITY_INDICATOR === 1'b0) seen[0] <= 1'b1;
	end
	task finish_test;
		if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [63:0] g, input logic [63:0] e);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task tmo;
		miscompares++;
		finish_test();
	endtask
	task step(input int n);
		repeat (n) @(posedge MCLK);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		int i;
		@(posedge MCLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= v;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge MCLK);
			if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
			if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
			if (S_AXI_BVALID) break;
		end
		resp = S_AXI_BRESP;
		S_AXI_BREADY <= 1'b0;
		if (i == 50) tmo();
	endtask
	task rd(input logic [7:0] a, output logic [31:0] v);
		int i;
		@(posedge MCLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge MCLK);
			if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
			if (S_AXI_RVALID) break;
		end
		v = S_AXI_RDATA;
		resp = S_AXI_RRESP;
		S_AXI_RREADY <= 1'b0;
		if (i == 50) tmo();
	endtask
	initial begin
		repeat (5) @(posedge MCLK);
		RSTN <= 1'b1;
		step(1);
		chk(LED_BOOT, 0);
		chk(HOST_ACTIVITY_INDICATOR, 0);
		step(30);
		chk(LED_BOOT, 1);
		chk(LED_RS485, 1);
		rd(`MCS_REG_NODE, d);
		chk(d, 32'h0028_0028);
		foreach (rows[i]) begin
			wr(`MCS_REG_RELAY, rows[i].w);
			@(posedge MCLK);
			{HOME_SWITCH_LEVEL, UPPER_LIMIT_SWITCH_LEVEL, LOWER_LIMIT_SWITCH_LEVEL} <= rows[i].sw;
			step(4);
			chk(RELAY_OUT, rows[i].relay);
			rd(`MCS_REG_SW, d);
			chk(d, {14'h0, rows[i].sw});
			rd(`MCS_REG_SWN, d);
			chk(d, {14'h0, ~rows[i].sw});
		end
		// disabled axes must stay quiet while commands pend
		wr(`MCS_REG_SENDEN, 32'h0);
		wr(`MCS_REG_CMD + 8'h08, 32'hc0de_0002);
		wr(`MCS_REG_CMD, 32'h1234_5678);
		step(20);
		chk(txq.size(), 0);
		@(posedge MCLK) slow <= 1'b1;
		wr(`MCS_REG_SENDEN, 32'h3f);
		for (int i = 0; i < 300 && txq.size() < 2; i++) @(posedge MCLK);
		if (txq.size() < 2) tmo();
		chk(txq[0], {11'h010, 32'h1234_5678});
		chk(txq[1], {11'h012, 32'hc0de_0002});
		mcs_partner_inst.send_fb(11'h024, 1'b0, 4'h4, 32'h0bad_cafe);
		mcs_partner_inst.send_fb(11'h024, 1'b1, 4'h4, 32'h1111_1111);
		mcs_partner_inst.send_fb(11'h024, 1'b0, 4'h3, 32'h2222_2222);
		rd(`MCS_REG_FB + 8'h10, d);
		chk(d, 32'h0bad_cafe);
		@(posedge MCLK) CAN_BUF_FULL <= 1'b1;
		step(3);
		chk(LED_CAN, 1);
		@(posedge MCLK) CAN_BUF_FULL <= 1'b0;
		wr(`MCS_REG_WDT, 32'd20);
		#1 seen = 2'b00;
		wr(`MCS_REG_CTRL, 32'h7);
		repeat (4) begin
			step(10);
			rd(`MCS_REG_STAT, d);
		end
		step(1);
		chk(AMP_POWER_ENABLE, 7'h7f);
		chk(seen, 2'b11);
		step(30);
		chk(AMP_POWER_ENABLE, 7'h00);
		chk(LED_ERROR, 1);
		rd(`MCS_REG_STAT, d);
		chk(d[0], 1);
		step(5);
		chk(AMP_POWER_ENABLE, 7'h00);
		rd(`MCS_REG_STAT, d);
		wr(`MCS_REG_CTRL, 32'h6);
		wr(`MCS_REG_CTRL, 32'h7);
		step(3);
		chk(AMP_POWER_ENABLE, 7'h7f);
		wr(`MCS_REG_CTRL, 32'h6);
		step(40);
		chk(AMP_POWER_ENABLE, 7'h7f);
		@(posedge MCLK) AMP_POWER_FAULT <= 1'b1;
		step(5);
		chk(AMP_POWER_ENABLE, 7'h00);
		@(posedge MCLK) AMP_POWER_FAULT <= 1'b0;
		rd(8'hfc, d);
		chk({resp, d}, {2'b10, 32'h0});
		wr(8'hfc, 32'h0);
		chk(resp, 2'b10);
		blk = 2'b00;
		repeat (20) begin
			step(1);
			blk[LED_ERROR] = 1'b1;
		end
		chk(blk, 2'b11);
		wr(`MCS_REG_STAT, 32'h10);
		chk(resp, 2'b00);
		rd(`MCS_REG_STAT, d);
		chk(d[4], 0);
		step(20);
		chk(LED_ERROR, 0);
		@(posedge MCLK) node_mask <= 16'h0008;
		step(40);
		rd(`MCS_REG_NODE, d);
		chk(d, 32'h0028_0008);
		chk(LED_RS485, 0);
		@(posedge MCLK) RSTN <= 1'b0;
		repeat (2) @(posedge MCLK);
		RSTN <= 1'b1;
		step(1);
		chk({LED_BOOT, AMP_POWER_ENABLE}, 8'h00);
		finish_test();
	end
endmodule
